// ### rtl/prp_regs.vh
// register map, field positions, reset values and timing constants
`ifndef PRP_REGS_VH
`define PRP_REGS_VH
`define PRP_TICK_CYC     16'h30D4
`define PRP_IX_CTRL      4'h0
`define PRP_IX_STAT      4'h1
`define PRP_IX_IRQ       4'h2
`define PRP_IX_MASK      4'h3
`define PRP_IX_NUM       4'h4
`define PRP_IX_DEN       4'h5
`define PRP_IX_ACCEL     4'h6
`define PRP_IX_MAVG      4'h7
`define PRP_IX_INPOS     4'h8
`define PRP_IX_NEAR      4'h9
`define PRP_IX_ERR       4'hA
`define PRP_B_RESTART    0
`define PRP_B_TSEL       4
`define PRP_TSEL_FILT    2'h1
`define PRP_TSEL_RAW     2'h2
`define PRP_RST_NUM      31'h00000004
`define PRP_RST_DEN      31'h00000001
`define PRP_RST_INPOS    31'h00000007
`define PRP_RST_NEAR     31'h40000000
`define PRP_RST_TIME     16'h0000
`define PRP_MAVG_MAX     14'h2710
`define PRP_GEAR_LO_INV  42'h000000003E8
`define PRP_GEAR_HI      42'h00000000FA0
`define PRP_DIV_STEPS    6'h30
`define PRP_MEM_AW       14
`define PRP_MEM_DW       32
`endif

// ### rtl/prp_mem.v
// history memory of the moving-average window, registered read
`timescale 1ns/10ps
`include "prp_regs.vh"
module prp_mem (
   input  wire                   clk_sys,   // system clock
   input  wire                   wr_en,     // write strobe
   input  wire [`PRP_MEM_AW-1:0] wr_addr,   // write address
   input  wire [`PRP_MEM_DW-1:0] wr_data,   // write data
   input  wire [`PRP_MEM_AW-1:0] rd_addr,   // read address
   output reg  [`PRP_MEM_DW-1:0] rd_data_q  // read data, one cycle later
);
   reg [`PRP_MEM_DW-1:0] mem_q [0:(1<<`PRP_MEM_AW)-1];

   // one write port, one registered read port
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
      rd_data_q <= mem_q[rd_addr];
   end
endmodule // prp_mem

// ### rtl/prp_core.v
// position reference path: gear, smoothing filters, error and position flags
//
// Behaviour
// - alarm when numerator over denominator is below 0.001 or above 4000
// - reference pulse count times numerator, divided by denominator
// - filters change timing only; total pulse count is kept exactly
// - accel time constant to 65535, moving-average time to 10000, 0.1 ms steps
// - a zero time setting bypasses its filter; both reset to zero
// - new filter times apply only when stopped with no reference pulses
// - in-position while absolute error below in-position width, default 7
// - timing select: error only, plus filtered zero, plus raw input zero
// - near flag while absolute error below near width, default 2^30
`timescale 1ns/10ps
`include "prp_regs.vh"
module prp_core #(
   parameter [15:0] TICK_CYC = `PRP_TICK_CYC  // cycles per control tick
) (
   input  wire        clk_sys,          // system clock, 125 MHz
   input  wire        sys_rst,          // synchronous reset, active high
   input  wire        ref_pulse_in,     // reference pulse pin, rising edge counts
   input  wire        ref_dir_in,       // reference direction pin, high = reverse
   input  wire        fb_valid,         // feedback increment strobe
   input  wire [15:0] fb_delta,         // signed feedback increment
   input  wire [5:0]  avs_address,      // avalon byte address
   input  wire        avs_read,         // avalon read
   input  wire        avs_write,        // avalon write
   input  wire [31:0] avs_writedata,    // avalon write data
   output wire [31:0] avs_readdata,     // avalon read data
   output wire        avs_waitrequest,  // avalon wait request
   output wire        in_position_flag, // positioning completed, active high
   output wire        near_flag,        // positioning near, active high
   output wire        gear_alarm,       // gear ratio out of range
   output wire        irq               // level interrupt
);
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_GDIV = 3'h1;
   localparam [2:0] S_EXP  = 3'h2;
   localparam [2:0] S_EDIV = 3'h3;
   localparam [2:0] S_MRD  = 3'h4;
   localparam [2:0] S_MRW  = 3'h5;
   localparam [2:0] S_MDIV = 3'h6;
   localparam [2:0] S_ACC  = 3'h7;
   localparam [15:0] TICK_LAST = TICK_CYC - 16'h0001;

   reg  [2:0]  st_q;
   reg  [2:0]  pul_s_q;
   reg  [1:0]  dir_s_q;
   reg  [15:0] tick_cnt_q;
   reg         tick_q;
   reg  [15:0] cnt_q;
   reg         fb_moved_q;
   reg  [30:0] num_set_q;
   reg  [30:0] den_set_q;
   reg  [30:0] num_act_q;
   reg  [30:0] den_act_q;
   reg  [1:0]  tsel_set_q;
   reg  [1:0]  tsel_act_q;
   reg  [15:0] accel_set_q;
   reg  [15:0] accel_act_q;
   reg  [13:0] mavg_set_q;
   reg  [13:0] mavg_act_q;
   reg  [30:0] inpos_w_q;
   reg  [30:0] near_w_q;
   reg         restart_q;
   reg  [2:0]  irq_st_q;
   reg  [2:0]  irq_msk_q;
   reg  [47:0] res_g_q;
   reg  [31:0] g_out_q;
   reg  [47:0] p_exp_q;
   reg  [31:0] e_out_q;
   reg  [47:0] box_sum_q;
   reg  [47:0] res_m_q;
   reg  [31:0] f_out_q;
   reg  [13:0] ptr_q;
   reg  [13:0] fill_q;
   reg  [47:0] err_q;
   reg         f_zero_q;
   reg         r_zero_q;
   reg         idle_q;
   reg  [47:0] dv_mag_q;
   reg  [31:0] dv_rem_q;
   reg  [31:0] dv_den_q;
   reg         dv_neg_q;
   reg  [5:0]  dv_cnt_q;
   reg         inpos_q;
   reg         near_q;
   reg         alarm_q;
   reg         irq_q;
   reg  [31:0] rdata_q;
   reg         wait_q;
   reg         ld_en;
   reg  [47:0] ld_val;
   reg  [31:0] ld_den;
   reg  [31:0] rd_mux;
   reg         inpos_d;
   wire [31:0] mem_rd;

   // sign extension to the wide datapath
   function [47:0] sx32;
      input [31:0] v;
      begin
         sx32 = {{16{v[31]}}, v};
      end
   endfunction

   wire        pul_edge = pul_s_q[1] & ~pul_s_q[2];
   wire        req      = avs_read | avs_write;
   wire        wr_go    = avs_write & ~wait_q;
   wire [3:0]  ix       = avs_address[5:2];
   wire        do_rst   = restart_q & (st_q == S_IDLE) & ~tick_q;
   wire        dv_done  = (dv_cnt_q == 6'h00);
   wire [32:0] dv_sh    = {dv_rem_q, dv_mag_q[47]};
   wire [32:0] dv_try   = dv_sh - {1'b0, dv_den_q};
   wire [47:0] q_s      = dv_neg_q ? -dv_mag_q : dv_mag_q;
   wire [47:0] r_s      = dv_neg_q ? -{16'h0000, dv_rem_q} : {16'h0000, dv_rem_q};
   wire [47:0] p_sum    = p_exp_q + sx32(g_out_q);
   wire [47:0] old_smp  = (fill_q == mavg_act_q) ? sx32(mem_rd) : 48'h0;
   wire [47:0] bs       = box_sum_q + sx32(e_out_q) - old_smp;
   wire [47:0] e_one    = p_exp_q[47] ? 48'hFFFFFFFFFFFF : 48'h000000000001;
   wire [47:0] e_fix    = ((q_s == 48'h0) && (p_exp_q != 48'h0)) ? e_one : q_s;
   wire [47:0] abs_err  = err_q[47] ? -err_q : err_q;
   wire        near_d   = abs_err < {17'h00000, near_w_q};
   wire        alarm_d  = (({11'h000, num_set_q} * `PRP_GEAR_LO_INV) < {11'h000, den_set_q}) |
                          ({11'h000, num_set_q} > ({11'h000, den_set_q} * `PRP_GEAR_HI));
   wire        idle_now = (cnt_q == 16'h0000) & ~fb_moved_q & (p_exp_q == 48'h0) &
                          (box_sum_q == 48'h0) & (res_m_q == 48'h0);
   wire [2:0]  ev       = {alarm_d & ~alarm_q, near_d & ~near_q, inpos_d & ~inpos_q};
   wire [2:0]  w1c      = (wr_go && ix == `PRP_IX_IRQ) ? avs_writedata[2:0] : 3'h0;
   wire [2:0]  irq_st_d = (irq_st_q & ~w1c) | ev;
   wire [47:0] err_add  = (st_q == S_ACC) ? sx32(f_out_q) : 48'h0;
   wire [47:0] err_sub  = fb_valid ? {{32{fb_delta[15]}}, fb_delta} : 48'h0;

   assign avs_readdata     = rdata_q;
   assign avs_waitrequest  = wait_q;
   assign in_position_flag = inpos_q;
   assign near_flag        = near_q;
   assign gear_alarm       = alarm_q;
   assign irq              = irq_q;

   // window history store
   prp_mem u_mem (
      .clk_sys   (clk_sys),
      .wr_en     (st_q == S_MRW),
      .wr_addr   (ptr_q),
      .wr_data   (e_out_q),
      .rd_addr   (ptr_q),
      .rd_data_q (mem_rd)
   );

   // pin synchronisers, third stage only for edge detect
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pul_s_q <= 3'h0;
         dir_s_q <= 2'h0;
      end else begin
         pul_s_q <= {pul_s_q[1:0], ref_pulse_in};
         dir_s_q <= {dir_s_q[0], ref_dir_in};
      end
   end

   // 0.1 ms control tick
   always @(posedge clk_sys) begin
      if (sys_rst || tick_cnt_q == TICK_LAST) begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= ~sys_rst;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         tick_q     <= 1'b0;
      end
   end

   // raw reference count per tick and motion detect
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_q      <= 16'h0000;
         fb_moved_q <= 1'b0;
      end else begin
         if (tick_q) begin
            cnt_q <= pul_edge ? (dir_s_q[1] ? 16'hFFFF : 16'h0001) : 16'h0000;
         end else if (pul_edge) begin
            cnt_q <= dir_s_q[1] ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
         end
         fb_moved_q <= (fb_valid && fb_delta != 16'h0000) | (fb_moved_q & ~tick_q);
      end
   end

   // divider load selection per stage
   always @* begin
      ld_en  = 1'b0;
      ld_val = 48'h0;
      ld_den = 32'h00000000;
      case (st_q)
         S_IDLE: begin
            ld_en  = tick_q;
            ld_val = res_g_q + {{32{cnt_q[15]}}, cnt_q} * {17'h00000, num_act_q};
            ld_den = {1'b0, den_act_q};
         end
         S_EXP: begin
            ld_en  = (accel_act_q != `PRP_RST_TIME);
            ld_val = p_sum;
            ld_den = {16'h0000, accel_act_q};
         end
         S_MRW: begin
            ld_en  = 1'b1;
            ld_val = res_m_q + bs;
            ld_den = {18'h00000, mavg_act_q};
         end
         default: ld_en = 1'b0;
      endcase
   end

   // shared restoring divider, quotient truncated, remainder kept
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         dv_mag_q <= 48'h0;
         dv_rem_q <= 32'h00000000;
         dv_den_q <= 32'h00000001;
         dv_neg_q <= 1'b0;
         dv_cnt_q <= 6'h00;
      end else if (ld_en) begin
         dv_neg_q <= ld_val[47];
         dv_mag_q <= ld_val[47] ? -ld_val : ld_val;
         dv_rem_q <= 32'h00000000;
         dv_den_q <= ld_den;
         dv_cnt_q <= `PRP_DIV_STEPS;
      end else if (!dv_done) begin
         dv_rem_q <= dv_try[32] ? dv_sh[31:0] : dv_try[31:0];
         dv_mag_q <= {dv_mag_q[46:0], ~dv_try[32]};
         dv_cnt_q <= dv_cnt_q - 6'h01;
      end
   end

   // per-tick sequence: gear, exponential, boxcar, hand to error
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q        <= S_IDLE;
         res_g_q     <= 48'h0;
         g_out_q     <= 32'h00000000;
         p_exp_q     <= 48'h0;
         e_out_q     <= 32'h00000000;
         box_sum_q   <= 48'h0;
         res_m_q     <= 48'h0;
         f_out_q     <= 32'h00000000;
         ptr_q       <= 14'h0000;
         fill_q      <= 14'h0000;
         f_zero_q    <= 1'b1;
         r_zero_q    <= 1'b1;
         idle_q      <= 1'b1;
         accel_act_q <= `PRP_RST_TIME;
         mavg_act_q  <= 14'h0000;
      end else if (do_rst) begin
         res_g_q   <= 48'h0;
         p_exp_q   <= 48'h0;
         box_sum_q <= 48'h0;
         res_m_q   <= 48'h0;
         ptr_q     <= 14'h0000;
         fill_q    <= 14'h0000;
      end else begin
         case (st_q)
            S_IDLE: if (tick_q) begin
               r_zero_q <= (cnt_q == 16'h0000);
               idle_q   <= idle_now;
               if (idle_now) begin
                  accel_act_q <= accel_set_q;
                  if (mavg_act_q != mavg_set_q) begin
                     mavg_act_q <= mavg_set_q;
                     ptr_q      <= 14'h0000;
                     fill_q     <= 14'h0000;
                  end
               end
               st_q <= S_GDIV;
            end
            S_GDIV: if (dv_done) begin
               res_g_q <= r_s;
               g_out_q <= q_s[31:0];
               st_q    <= S_EXP;
            end
            S_EXP: begin
               if (accel_act_q == `PRP_RST_TIME) begin
                  e_out_q <= g_out_q;
                  st_q    <= S_MRD;
               end else begin
                  p_exp_q <= p_sum;
                  st_q    <= S_EDIV;
               end
            end
            S_EDIV: if (dv_done) begin
               e_out_q <= e_fix[31:0];
               p_exp_q <= p_exp_q - e_fix;
               st_q    <= S_MRD;
            end
            S_MRD: begin
               if (mavg_act_q == 14'h0000) begin
                  f_out_q <= e_out_q;
                  st_q    <= S_ACC;
               end else begin
                  st_q <= S_MRW;
               end
            end
            S_MRW: begin
               box_sum_q <= bs;
               ptr_q     <= (ptr_q == mavg_act_q - 14'h0001) ? 14'h0000 : ptr_q + 14'h0001;
               if (fill_q != mavg_act_q) begin
                  fill_q <= fill_q + 14'h0001;
               end
               st_q <= S_MDIV;
            end
            S_MDIV: if (dv_done) begin
               res_m_q <= r_s;
               f_out_q <= q_s[31:0];
               st_q    <= S_ACC;
            end
            S_ACC: begin
               f_zero_q <= (f_out_q == 32'h00000000);
               st_q     <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // signed position error accumulator
   always @(posedge clk_sys) begin
      if (sys_rst || do_rst) begin
         err_q <= 48'h0;
      end else begin
         err_q <= err_q + err_add - err_sub;
      end
   end

   // in-position condition by timing select
   always @* begin
      inpos_d = abs_err < {17'h00000, inpos_w_q};
      case (tsel_act_q)
         `PRP_TSEL_FILT: inpos_d = inpos_d & f_zero_q;
         `PRP_TSEL_RAW:  inpos_d = inpos_d & r_zero_q;
         default:        inpos_d = inpos_d;
      endcase
   end

   // flags, alarm and interrupt, event set wins over clear
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         inpos_q  <= 1'b0;
         near_q   <= 1'b0;
         alarm_q  <= 1'b0;
         irq_st_q <= 3'h0;
         irq_q    <= 1'b0;
      end else begin
         inpos_q  <= inpos_d;
         near_q   <= near_d;
         alarm_q  <= alarm_d;
         irq_st_q <= irq_st_d;
         irq_q    <= |(irq_st_d & irq_msk_q);
      end
   end

   // settings written by software
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         num_set_q   <= `PRP_RST_NUM;
         den_set_q   <= `PRP_RST_DEN;
         num_act_q   <= `PRP_RST_NUM;
         den_act_q   <= `PRP_RST_DEN;
         tsel_set_q  <= 2'h0;
         tsel_act_q  <= 2'h0;
         accel_set_q <= `PRP_RST_TIME;
         mavg_set_q  <= 14'h0000;
         inpos_w_q   <= `PRP_RST_INPOS;
         near_w_q    <= `PRP_RST_NEAR;
         irq_msk_q   <= 3'h0;
         restart_q   <= 1'b0;
      end else begin
         if (do_rst) begin
            num_act_q  <= num_set_q;
            den_act_q  <= den_set_q;
            tsel_act_q <= tsel_set_q;
            restart_q  <= 1'b0;
         end
         if (wr_go) begin
            case (ix)
               `PRP_IX_CTRL: begin
                  tsel_set_q <= avs_writedata[`PRP_B_TSEL+1:`PRP_B_TSEL];
                  restart_q  <= avs_writedata[`PRP_B_RESTART] | (restart_q & ~do_rst);
               end
               `PRP_IX_MASK:  irq_msk_q <= avs_writedata[2:0];
               `PRP_IX_NUM:   num_set_q <= avs_writedata[30:0];
               `PRP_IX_DEN:   den_set_q <= (avs_writedata[30:0] == 31'h0) ?
                                           `PRP_RST_DEN : avs_writedata[30:0];
               `PRP_IX_ACCEL: accel_set_q <= avs_writedata[15:0];
               `PRP_IX_MAVG:  mavg_set_q <= (avs_writedata > {18'h00000, `PRP_MAVG_MAX}) ?
                                            `PRP_MAVG_MAX : avs_writedata[13:0];
               `PRP_IX_INPOS: inpos_w_q <= avs_writedata[30:0];
               `PRP_IX_NEAR:  near_w_q <= (avs_writedata[30:0] == 31'h0) ?
                                          31'h00000001 : avs_writedata[30:0];
               default:       ;
            endcase
         end
      end
   end

   // read data selection
   always @* begin
      case (ix)
         `PRP_IX_CTRL:  rd_mux = {26'h0, tsel_set_q, 3'h0, restart_q};
         `PRP_IX_STAT:  rd_mux = {28'h0, idle_q, alarm_q, near_q, inpos_q};
         `PRP_IX_IRQ:   rd_mux = {29'h0, irq_st_q};
         `PRP_IX_MASK:  rd_mux = {29'h0, irq_msk_q};
         `PRP_IX_NUM:   rd_mux = {1'b0, num_set_q};
         `PRP_IX_DEN:   rd_mux = {1'b0, den_set_q};
         `PRP_IX_ACCEL: rd_mux = {16'h0000, accel_set_q};
         `PRP_IX_MAVG:  rd_mux = {18'h00000, mavg_set_q};
         `PRP_IX_INPOS: rd_mux = {1'b0, inpos_w_q};
         `PRP_IX_NEAR:  rd_mux = {1'b0, near_w_q};
         `PRP_IX_ERR:   rd_mux = err_q[31:0];
         default:       rd_mux = 32'h00000000;
      endcase
   end

   // avalon slave, one wait cycle per access
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else if (req && wait_q) begin
         wait_q  <= 1'b0;
         rdata_q <= rd_mux;
      end else begin
         wait_q <= 1'b1;
      end
   end
endmodule // prp_core

// ### bench/prp_core_sva.sv
// port checker for the position reference core
`timescale 1ns/10ps
module prp_core_sva #(
   parameter [15:0] TICK_CYC = 16'h30D4  // cycles per control tick
) (
   input wire        clk_sys,          // system clock
   input wire        sys_rst,          // sync reset
   input wire        ref_pulse_in,     // pulse pin
   input wire        ref_dir_in,       // direction pin
   input wire        fb_valid,         // feedback strobe
   input wire [15:0] fb_delta,         // feedback step
   input wire [5:0]  avs_address,      // bus address
   input wire        avs_read,         // bus read
   input wire        avs_write,        // bus write
   input wire [31:0] avs_writedata,    // bus write data
   input wire [31:0] avs_readdata,     // bus read data
   input wire        avs_waitrequest,  // bus wait
   input wire        in_position_flag, // in position
   input wire        near_flag,        // near
   input wire        gear_alarm,       // ratio alarm
   input wire        irq               // interrupt
);
   reg  [31:0] quiet_q;                      // cycles since last stimulus
   wire        req = avs_read || avs_write;  // bus request pending
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // quiet counter, restarted by pulse level, feedback or write
   always @(posedge clk_sys) begin
      if (sys_rst || ref_pulse_in || fb_valid || avs_write)
         quiet_q <= 32'h0;
      else if (quiet_q != 32'hFFFFFFFF)
         quiet_q <= quiet_q + 32'h1;
   end
   property p_rst_vals; $fell(sys_rst) |-> avs_waitrequest && avs_readdata == 32'h0
      && !in_position_flag && !near_flag && !gear_alarm && !irq; endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle after reset");
   property p_wait_ans; req && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("bus request not answered");
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low longer than one cycle");
   property p_wait_cause; !avs_waitrequest |-> $past(req && avs_waitrequest); endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   property p_rd_stable; !$stable(avs_readdata) |-> $past(req && avs_waitrequest); endproperty
   a_rd_stable: assert property (p_rd_stable) else $error("read data moved between accesses");
   property p_alarm_cause; !$stable(gear_alarm) |-> $past(avs_write, 1) || $past(avs_write, 2)
      || $past(avs_write, 3); endproperty
   a_alarm_cause: assert property (p_alarm_cause) else $error("alarm moved without write");
   property p_inpos_near; in_position_flag |-> near_flag; endproperty
   a_inpos_near: assert property (p_inpos_near) else $error("in position but not near");
   property p_flag_quiet; quiet_q >= 32'h1E * TICK_CYC |->
      $stable(in_position_flag) && $stable(near_flag); endproperty
   a_flag_quiet: assert property (p_flag_quiet) else $error("flags moved while quiet");
endmodule // prp_core_sva

bind prp_core prp_core_sva #(.TICK_CYC(TICK_CYC)) u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .ref_pulse_in(ref_pulse_in), .ref_dir_in(ref_dir_in), .fb_valid(fb_valid),
   .fb_delta(fb_delta), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .in_position_flag(in_position_flag),
   .near_flag(near_flag), .gear_alarm(gear_alarm), .irq(irq));

// ### bench/prp_host.sv
// behavioural host controller issuing reference pulse trains
`timescale 1ns/10ps
module prp_host (
   input  wire       clk_sys,      // system clock
   input  wire       go,           // start a train
   input  wire [7:0] n_pulse,      // pulses in the train
   input  wire       rev,          // reverse direction
   input  wire [7:0] half,         // half period in clocks, 3 or more
   output reg        ref_pulse_in, // pulse pin
   output reg        ref_dir_in,   // direction pin
   output reg        busy          // train running
);
   // one train per go, direction settled before and after the edges
   initial begin
      ref_pulse_in = 1'b0;
      ref_dir_in   = 1'b0;
      busy         = 1'b0;
      forever begin
         @(posedge clk_sys);
         if (go === 1'b1) begin
            busy       <= 1'b1;
            ref_dir_in <= rev;
            repeat (4) @(posedge clk_sys);
            repeat (n_pulse) begin
               ref_pulse_in <= 1'b1;
               repeat (half) @(posedge clk_sys);
               ref_pulse_in <= 1'b0;
               repeat (half) @(posedge clk_sys);
            end
            repeat (4) @(posedge clk_sys);
            busy <= 1'b0;
         end
      end
   end
endmodule // prp_host

// ### bench/tb_top.sv
// self-checking bench for the position reference core
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {logic w; logic [5:0] a; logic [31:0] d, e; logic al;} prp_row_t;
   logic        clk_sys, sys_rst = 1'b1, fb_valid = 1'b0, go = 1'b0, rev = 1'b0;
   logic        avs_read = 1'b0, avs_write = 1'b0, ref_pulse_in, ref_dir_in, busy;
   logic        avs_waitrequest, in_position_flag, near_flag, gear_alarm, irq;
   logic [15:0] fb_delta = 16'h0000;
   logic [7:0]  n_pulse = 8'h00, half = 8'h03;
   logic [5:0]  avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   int          n_mismatch = 0, n_tests = 0;
   // register cases: write flag, address, write value, read-back, alarm
   prp_row_t rows [0:21] = '{
      '{1'h0, 6'h10, 32'h0, 32'h4, 1'h0}, '{1'h0, 6'h14, 32'h0, 32'h1, 1'h0},
      '{1'h0, 6'h18, 32'h0, 32'h0, 1'h0}, '{1'h0, 6'h1C, 32'h0, 32'h0, 1'h0},
      '{1'h0, 6'h20, 32'h0, 32'h7, 1'h0}, '{1'h0, 6'h24, 32'h0, 32'h40000000, 1'h0},
      '{1'h0, 6'h28, 32'h0, 32'h0, 1'h0}, '{1'h1, 6'h10, 32'h1, 32'h1, 1'h0},
      '{1'h1, 6'h14, 32'h3E8, 32'h3E8, 1'h0}, '{1'h1, 6'h14, 32'h3E9, 32'h3E9, 1'h1},
      '{1'h1, 6'h10, 32'hFA0, 32'hFA0, 1'h0}, '{1'h1, 6'h14, 32'h1, 32'h1, 1'h0},
      '{1'h1, 6'h10, 32'hFA1, 32'hFA1, 1'h1}, '{1'h1, 6'h14, 32'h0, 32'h1, 1'h1},
      '{1'h1, 6'h10, 32'h4, 32'h4, 1'h0}, '{1'h1, 6'h18, 32'hFFFF, 32'hFFFF, 1'h0},
      '{1'h1, 6'h18, 32'h0, 32'h0, 1'h0}, '{1'h1, 6'h1C, 32'h4E20, 32'h2710, 1'h0},
      '{1'h1, 6'h1C, 32'h0, 32'h0, 1'h0}, '{1'h1, 6'h24, 32'h0, 32'h1, 1'h0},
      '{1'h1, 6'h2C, 32'h5, 32'h0, 1'h0}, '{1'h0, 6'h04, 32'h0, 32'hB, 1'h0}};
   prp_core #(.TICK_CYC(16'h00C8)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .ref_pulse_in(ref_pulse_in), .ref_dir_in(ref_dir_in), .fb_valid(fb_valid),
      .fb_delta(fb_delta), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .in_position_flag(in_position_flag),
      .near_flag(near_flag), .gear_alarm(gear_alarm), .irq(irq));
   prp_host u_host (.clk_sys(clk_sys), .go(go), .n_pulse(n_pulse), .rev(rev), .half(half),
      .ref_pulse_in(ref_pulse_in), .ref_dir_in(ref_dir_in), .busy(busy));
   // 125 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task close_out;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task tmo(input string nm);
      n_mismatch++;
      $display("CHECK FAILED %s expected answer seen none", nm);
      close_out;
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // one bus transfer, held until waitrequest is sampled low
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (i = 0; avs_waitrequest !== 1'b0 || i == 0; i++) begin
         if (i == 20) tmo("waitrequest");
         @(posedge clk_sys);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [5:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   // read the error register until it settles on the expected value
   task poll(input logic [31:0] e);
      int i;
      rd(6'h28);
      for (i = 0; q !== e; i++) begin
         if (i == 1000) tmo("err poll");
         idle(10);
         rd(6'h28);
      end
      rd(6'h28);
      chk("err", q, e);
   endtask
   task flags(input logic ei, input logic en);
      chk("in_position_flag", in_position_flag, ei);
      chk("near_flag", near_flag, en);
   endtask
   task fb(input logic [15:0] d);
      @(posedge clk_sys);
      fb_valid <= 1'b1;
      fb_delta <= d;
      @(posedge clk_sys);
      fb_valid <= 1'b0;
   endtask
   task start(input logic [7:0] n, input logic r, input logic [7:0] h);
      int i;
      @(posedge clk_sys);
      go <= 1'b1;
      n_pulse <= n;
      rev <= r;
      half <= h;
      @(posedge clk_sys);
      go <= 1'b0;
      for (i = 0; busy !== 1'b1; i++) begin
         if (i == 10) tmo("host start");
         @(posedge clk_sys);
      end
   endtask
   task done;
      int i;
      for (i = 0; busy !== 1'b0; i++) begin
         if (i == 20000) tmo("host done");
         @(posedge clk_sys);
      end
   endtask
   // main sequence
   initial begin
      int m;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      idle(4);
      foreach (rows[i]) begin
         if (rows[i].w === 1'b1) wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk("reg", q, rows[i].e);
         chk("gear_alarm", gear_alarm, rows[i].al);
      end
      // sticky status, mask and write-one-to-clear
      rd(6'h08);
      chk("irq_stat", q, 32'h7);
      chk("irq", irq, 1'b0);
      wr(6'h0C, 32'h4);
      idle(2);
      chk("irq", irq, 1'b1);
      wr(6'h08, 32'h4);
      idle(2);
      chk("irq", irq, 1'b0);
      wr(6'h08, 32'h3);
      wr(6'h0C, 32'h3);
      rd(6'h08);
      chk("irq_stat", q, 32'h0);
      // error against both widths at their boundaries
      wr(6'h24, 32'h8);
      start(8'h02, 1'b0, 8'h03);
      done;
      poll(32'h8);
      flags(1'b0, 1'b0);
      fb(16'h0001);
      poll(32'h7);
      flags(1'b0, 1'b1);
      fb(16'h0001);
      poll(32'h6);
      flags(1'b1, 1'b1);
      chk("irq", irq, 1'b1);
      fb(16'h0006);
      poll(32'h0);
      start(8'h02, 1'b1, 8'h05);
      done;
      poll(32'hFFFFFFF8);
      flags(1'b0, 1'b0);
      fb(16'hFFF8);
      poll(32'h0);
      // timing select modes, sampled in mid-train and after it
      wr(6'h20, 32'h3E8);
      wr(6'h24, 32'h7D0);
      for (m = 0; m < 4; m++) begin
         wr(6'h00, {26'h0, m[1:0], 4'h1});
         idle(250);
         start(8'h0A, 1'b0, 8'h32);
         idle(600);
         chk("in_pos_mid", in_position_flag, m == 0 || m == 3);
         rd(6'h04);
         chk("idle_mid", q[3], 1'b0);
         done;
         poll(32'h28);
         idle(600);
         chk("in_pos_end", in_position_flag, 1'b1);
      end
      // smoothing on: timing reshaped, total count kept
      wr(6'h00, 32'h1);
      idle(250);
      wr(6'h18, 32'h3);
      wr(6'h1C, 32'h2);
      idle(600);
      start(8'h05, 1'b0, 8'h03);
      done;
      idle(400);
      rd(6'h28);
      chk("err_smooth", q < 32'h14, 1'b1);
      poll(32'h14);
      // mid-run reset brings the accel setting back to its default
      sys_rst <= 1'b1;
      idle(2);
      sys_rst <= 1'b0;
      rd(6'h18);
      chk("accel_rst", q, 32'h0);
      close_out;
   end
endmodule // tb_top
